/* File: pkg/mesp_defines.svh */
// named constants of the emergency-stop protection block
// assumes a 32-bit register port with an 8-bit byte address
`ifndef MESP_DEFINES_SVH
`define MESP_DEFINES_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define MESP_ADDR_W 8
`define MESP_ADDR_CTRL 8'h00
`define MESP_ADDR_KEY 8'h04
`define MESP_ADDR_STAT 8'h08
`define MESP_ADDR_ALTREL 8'h0C
`define MESP_ADDR_ISTAT 8'h10
`define MESP_ADDR_ICLR 8'h14
`define MESP_ADDR_IEN 8'h18

// ------------------------------------------------------------
// control, release, status and key register fields
// ------------------------------------------------------------
`define MESP_CTRL_EN 0
`define MESP_CTRL_REL 1
`define MESP_CTRL_MODE_LO 3
`define MESP_CTRL_MODE_HI 4
`define MESP_CTRL_TOOL 5
`define MESP_CTRL_CNT_LO 8
`define MESP_CTRL_CNT_HI 11
`define MESP_ALTREL_BIT 0
`define MESP_STAT_PROT 0
`define MESP_STAT_PIN 1
`define MESP_KEY_HI 7

// ------------------------------------------------------------
// values and reset values
// ------------------------------------------------------------
`define MESP_KEY_FIRST 8'h5A
`define MESP_KEY_SECOND 8'hA5
`define MESP_MODE_UPPER_ON 2'h1
`define MESP_MODE_LOWER_ON 2'h2
`define MESP_RST_MODE 2'h3
`define MESP_RST_ON 1'h1
`define MESP_COND_W 12
`define MESP_COND_IDLE 12'h000
`define MESP_FILT_UNIT 4
`define MESP_CNT_ZERO 4'h0
`define MESP_IRQ_W 2
`define MESP_IRQ_EMG 0
`define MESP_IRQ_TOOL 1
`define MESP_UPPER_OE 6'h07
`define MESP_LOWER_OE 6'h38
`define MESP_ALL_OE 6'h3F
`define MESP_NONE 6'h00

`endif

/* File: pkg/mesp_pkg.sv */
// types of the emergency-stop protection block
// assumes mesp_defines.svh is on the include path
package mesp_pkg;
  `include "mesp_defines.svh"

  typedef enum logic [1:0] {
    MESP_KEY_IDLE,
    MESP_KEY_HALF,
    MESP_KEY_ARMED
  } mesp_key_t;

  typedef struct packed {
    logic [3:0] filt_cnt;
    logic tool_en;
    logic [1:0] mode;
    logic prot_en;
    logic prot;
    mesp_key_t key;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic pin;
    logic flt_prev;
    logic tool_prev;
    logic [5:0] phase;
    logic [5:0] phase_oe;
    logic [31:0] rdata;
  } mesp_state_t;

  typedef struct packed {
    logic level;
    logic [7:0] count;
  } mesp_filt_t;

  localparam mesp_state_t MESP_STATE_RST = '{
    tool_en: `MESP_RST_ON,
    mode: `MESP_RST_MODE,
    prot_en: `MESP_RST_ON,
    key: MESP_KEY_IDLE,
    pin: `MESP_RST_ON,
    flt_prev: `MESP_RST_ON,
    default: '0
  };
  localparam mesp_filt_t MESP_FILT_RST = '{
    level: `MESP_RST_ON,
    default: '0
  };
endpackage

/* File: pkg/mesp_filt_if.sv */
// link between the protection top and its input noise filter
// assumes both ends share one clock
`timescale 1ns/100ps
interface mesp_filt_if;
  logic raw;
  logic [3:0] cnt;
  logic level;
  modport filt (input raw, input cnt, output level);
  modport user (output raw, output cnt, input level);
endinterface

/* File: hdl/mesp_filter.sv */
// noise filter for the active-low emergency input
// assumes raw is synchronous to i_clock
`timescale 1ns/100ps
module mesp_filter
  import mesp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  mesp_filt_if.filt f
);
  import mesp_pkg::*;

  mesp_filt_t st_r;
  mesp_filt_t st_nxt;
  logic [7:0] span;

  // for nonzero cnt a new level is taken only after it held for cnt*16 clocks
  assign span = 8'(f.cnt) << `MESP_FILT_UNIT;
  assign f.level = st_r.level;

  always_comb begin
    st_nxt = st_r;
    if (f.cnt == `MESP_CNT_ZERO) begin
      st_nxt.level = f.raw;
      st_nxt.count = '0;
    end else if (f.raw == st_r.level) begin
      st_nxt.count = '0;
    end else if (8'(st_r.count + 8'h01) >= span) begin
      st_nxt.level = f.raw;
      st_nxt.count = '0;
    end else begin
      st_nxt.count = 8'(st_r.count + 8'h01);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r <= MESP_FILT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  bypass_follows_a: assert property (
    f.cnt == `MESP_CNT_ZERO |=> f.level == $past(f.raw))
    else $error("filter bypass does not follow input");
  short_glitch_a: assert property (
    f.cnt != `MESP_CNT_ZERO && f.raw != f.level && $stable(f.cnt)
    ##1 f.raw == f.level |=> $stable(f.level))
    else $error("one-cycle glitch passed the filter");
endmodule

/* File: hdl/mesp_top.sv */
// emergency-stop protection for a three-phase pwm output stage
// assumes a one-cycle register port and pwm inputs on i_clock
`timescale 1ns/100ps

// Functional notes
// - a falling filtered emergency input while enabled forces the protection pattern and raises the interrupt.
// - the mode field picks all high-z, upper switching with lower high-z, or the reverse.
// - with tool break enabled the tool stop disables all outputs as the port mode selects unless protection is active, with tool break disabled it is ignored.
// - the protection flag reads 1 while protection is active and 0 otherwise.
// - a release write only succeeds when the conduction buffer holds zero, and a second register also releases.
// - a release is ignored while the emergency input is low.
// - the release bit is write-only, writing 0 does nothing and it reads 0.
// - clearing the enable is accepted only right after the full key sequence.
// - the key sequence is consumed by the next access and each clear needs a fresh key.
// - the input filter needs the level stable for count times 16 clocks, count 0 bypasses it.
// - after reset enable and tool break are 1 and the mode is 11.
// - a read-only bit shows the emergency input pin level.
module mesp_top
  import mesp_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [`MESP_ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic I_EMERGENCY_STOP_N,
  input wire logic I_TOOL_STOP,
  input wire logic I_TOOL_BREAK_PORT_MODE,
  input wire logic [`MESP_COND_W-1:0] I_COND_BUF,
  input wire logic [5:0] I_PWM,
  output logic [5:0] O_PHASE,
  output logic [5:0] O_PHASE_OE,
  output logic O_EMERGENCY_INTERRUPT
);
  import mesp_pkg::*;

  // ------------------------------------------------------------
  // state and decode
  // ------------------------------------------------------------
  mesp_state_t state_r;
  mesp_state_t state_nxt;
  mesp_filt_if flt ();

  logic wr_ctrl;
  logic wr_key;
  logic wr_alt;
  logic wr_iclr;
  logic wr_ien;
  logic access;
  logic key_armed;
  logic key_first;
  logic key_second;
  logic flt_fall;
  logic tool_brk;
  logic release_req;
  logic release_ok;
  logic [`MESP_IRQ_W-1:0] events;

  assign wr_ctrl = I_WR && (I_ADDR == `MESP_ADDR_CTRL);
  assign wr_key = I_WR && (I_ADDR == `MESP_ADDR_KEY);
  assign wr_alt = I_WR && (I_ADDR == `MESP_ADDR_ALTREL);
  assign wr_iclr = I_WR && (I_ADDR == `MESP_ADDR_ICLR);
  assign wr_ien = I_WR && (I_ADDR == `MESP_ADDR_IEN);
  assign access = I_WR || I_RD;
  assign key_armed = (state_r.key == MESP_KEY_ARMED);
  assign key_first = wr_key && (I_WDATA[`MESP_KEY_HI:0] == `MESP_KEY_FIRST);
  assign key_second = wr_key && (I_WDATA[`MESP_KEY_HI:0] == `MESP_KEY_SECOND);

  assign flt.raw = I_EMERGENCY_STOP_N;
  assign flt.cnt = state_r.filt_cnt;

  mesp_filter u_filter (
    .i_clock(I_CLOCK),
    .i_rst(I_RST),
    .f(flt.filt)
  );

  // an edge, not the level, arms protection: a pin held low keeps
  // protection up only through the release refusal below
  assign flt_fall = state_r.flt_prev && !flt.level;
  assign tool_brk = I_TOOL_STOP && state_r.tool_en;
  assign release_req = (wr_ctrl && I_WDATA[`MESP_CTRL_REL])
    || (wr_alt && I_WDATA[`MESP_ALTREL_BIT]);
  // both the raw pin and the filtered level must be back high
  assign release_ok = release_req && flt.level && I_EMERGENCY_STOP_N
    && (I_COND_BUF == `MESP_COND_IDLE);
  assign events[`MESP_IRQ_EMG] = flt_fall && state_r.prot_en;
  assign events[`MESP_IRQ_TOOL] = tool_brk && !state_r.tool_prev;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.pin = I_EMERGENCY_STOP_N;
    state_nxt.flt_prev = flt.level;
    state_nxt.tool_prev = tool_brk;
    state_nxt.rdata = '0;

    if (wr_ctrl) begin
      state_nxt.filt_cnt = I_WDATA[`MESP_CTRL_CNT_HI:`MESP_CTRL_CNT_LO];
      state_nxt.tool_en = I_WDATA[`MESP_CTRL_TOOL];
      state_nxt.mode = I_WDATA[`MESP_CTRL_MODE_HI:`MESP_CTRL_MODE_LO];
      // a clear without the key is dropped, setting is always allowed
      if (I_WDATA[`MESP_CTRL_EN] || key_armed) begin
        state_nxt.prot_en = I_WDATA[`MESP_CTRL_EN];
      end
    end

    // key sequence: each access consumes or abandons it
    case (state_r.key)
      MESP_KEY_IDLE: begin
        if (key_first) begin
          state_nxt.key = MESP_KEY_HALF;
        end
      end
      MESP_KEY_HALF: begin
        if (key_second) begin
          state_nxt.key = MESP_KEY_ARMED;
        end else if (key_first) begin
          state_nxt.key = MESP_KEY_HALF;
        end else if (access) begin
          state_nxt.key = MESP_KEY_IDLE;
        end
      end
      MESP_KEY_ARMED: begin
        if (key_first) begin
          state_nxt.key = MESP_KEY_HALF;
        end else if (access) begin
          state_nxt.key = MESP_KEY_IDLE;
        end
      end
      default: begin
        state_nxt.key = MESP_KEY_IDLE;
      end
    endcase

    // protection state: a new fall wins over a release
    if (!state_nxt.prot_en) begin
      state_nxt.prot = 1'b0;
    end else if (events[`MESP_IRQ_EMG]) begin
      state_nxt.prot = 1'b1;
    end else if (release_ok) begin
      state_nxt.prot = 1'b0;
    end

    // sticky events: a set in the clear cycle survives
    state_nxt.irq_stat = state_r.irq_stat & ~({`MESP_IRQ_W{wr_iclr}}
      & I_WDATA[`MESP_IRQ_W-1:0]);
    state_nxt.irq_stat = state_nxt.irq_stat | events;
    if (wr_ien) begin
      state_nxt.irq_en = I_WDATA[`MESP_IRQ_W-1:0];
    end

    // output pattern, emergency before tool break
    state_nxt.phase = I_PWM;
    state_nxt.phase_oe = `MESP_ALL_OE;
    if (state_r.prot) begin
      if (state_r.mode == `MESP_MODE_UPPER_ON) begin
        state_nxt.phase_oe = `MESP_UPPER_OE;
      end else if (state_r.mode == `MESP_MODE_LOWER_ON) begin
        state_nxt.phase_oe = `MESP_LOWER_OE;
      end else begin
        state_nxt.phase_oe = `MESP_NONE;
      end
    end else if (tool_brk) begin
      state_nxt.phase = `MESP_NONE;
      if (I_TOOL_BREAK_PORT_MODE) begin
        state_nxt.phase_oe = `MESP_NONE;
      end
    end

    // read data; the release bits never read back
    if (I_RD) begin
      if (I_ADDR == `MESP_ADDR_CTRL) begin
        state_nxt.rdata[`MESP_CTRL_EN] = state_r.prot_en;
        state_nxt.rdata[`MESP_CTRL_MODE_HI:`MESP_CTRL_MODE_LO] =
          state_r.mode;
        state_nxt.rdata[`MESP_CTRL_TOOL] = state_r.tool_en;
        state_nxt.rdata[`MESP_CTRL_CNT_HI:`MESP_CTRL_CNT_LO] =
          state_r.filt_cnt;
      end else if (I_ADDR == `MESP_ADDR_STAT) begin
        state_nxt.rdata[`MESP_STAT_PROT] = state_r.prot;
        state_nxt.rdata[`MESP_STAT_PIN] = state_r.pin;
      end else if (I_ADDR == `MESP_ADDR_ISTAT) begin
        state_nxt.rdata[`MESP_IRQ_W-1:0] = state_r.irq_stat;
      end else if (I_ADDR == `MESP_ADDR_IEN) begin
        state_nxt.rdata[`MESP_IRQ_W-1:0] = state_r.irq_en;
      end else begin
        state_nxt.rdata = '0;
      end
    end
  end

  // reset values come from the package constant
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state_r <= MESP_STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign O_RDATA = state_r.rdata;
  assign O_PHASE = state_r.phase;
  assign O_PHASE_OE = state_r.phase_oe;
  // level output: stays up until software clears the flag or the enable
  assign O_EMERGENCY_INTERRUPT = |(state_r.irq_stat & state_r.irq_en);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  fall_sets_prot_a: assert property (
    flt_fall && state_r.prot_en && state_nxt.prot_en
    |=> state_r.prot && state_r.irq_stat[`MESP_IRQ_EMG]
    ##1 O_PHASE_OE != `MESP_ALL_OE)
    else $error("emergency fall did not enter protection");
  upper_mode_a: assert property (
    state_r.prot && state_r.mode == `MESP_MODE_UPPER_ON
    |=> O_PHASE_OE == `MESP_UPPER_OE && O_PHASE == $past(I_PWM))
    else $error("upper-on pattern wrong");
  highz_mode_a: assert property (
    state_r.prot && state_r.mode != `MESP_MODE_UPPER_ON
    && state_r.mode != `MESP_MODE_LOWER_ON |=> O_PHASE_OE == `MESP_NONE)
    else $error("all high-z pattern wrong");
  tool_stop_a: assert property (
    !state_r.prot && I_TOOL_STOP && state_r.tool_en
    |=> O_PHASE == `MESP_NONE
    && O_PHASE_OE == ($past(I_TOOL_BREAK_PORT_MODE) ? `MESP_NONE
    : `MESP_ALL_OE))
    else $error("tool break pattern wrong");
  tool_ignored_a: assert property (
    !state_r.prot && !state_r.tool_en
    |=> O_PHASE_OE == `MESP_ALL_OE && O_PHASE == $past(I_PWM))
    else $error("tool stop not ignored");
  status_read_a: assert property (
    I_RD && I_ADDR == `MESP_ADDR_STAT
    |=> O_RDATA[`MESP_STAT_PROT] == $past(state_r.prot)
    && O_RDATA[`MESP_STAT_PIN] == $past(state_r.pin))
    else $error("status read wrong");
  release_refused_a: assert property (
    state_r.prot && state_r.prot_en && !key_armed
    && I_COND_BUF != `MESP_COND_IDLE |=> state_r.prot)
    else $error("release taken with conduction active");
  low_input_holds_a: assert property (
    state_r.prot && !I_EMERGENCY_STOP_N && !key_armed |=> state_r.prot)
    else $error("release taken while input low");
  release_reads_zero_a: assert property (
    I_RD && I_ADDR == `MESP_ADDR_CTRL |=> !O_RDATA[`MESP_CTRL_REL])
    else $error("release bit read as one");
  keyless_clear_a: assert property (
    wr_ctrl && !I_WDATA[`MESP_CTRL_EN] && !key_armed && state_r.prot_en
    |=> state_r.prot_en)
    else $error("enable cleared without key");
  key_abandon_a: assert property (
    state_r.key == MESP_KEY_HALF && access && !wr_key
    |=> state_r.key == MESP_KEY_IDLE)
    else $error("partial key survived other access");
  lower_mode_a: assert property (
    state_r.prot && state_r.mode == `MESP_MODE_LOWER_ON
    |=> O_PHASE_OE == `MESP_LOWER_OE && O_PHASE == $past(I_PWM))
    else $error("lower-on pattern wrong");
  release_taken_a: assert property (
    state_r.prot && release_req && flt.level && I_EMERGENCY_STOP_N
    && I_COND_BUF == `MESP_COND_IDLE |=> !state_r.prot)
    else $error("allowed release was not taken");

  // interrupt flags: only a clear write may drop a recorded event
  emg_sticky_a: assert property (
    state_r.irq_stat[`MESP_IRQ_EMG] && !wr_iclr
    |=> state_r.irq_stat[`MESP_IRQ_EMG])
    else $error("emergency flag dropped without a clear");
  tool_flag_a: assert property (
    tool_brk && !state_r.tool_prev |=> state_r.irq_stat[`MESP_IRQ_TOOL])
    else $error("tool break event not recorded");

  // an armed key serves exactly one following access
  armed_consumed_a: assert property (
    key_armed && access && !key_first
    |=> state_r.key == MESP_KEY_IDLE)
    else $error("armed key survived an access");
  disable_clears_a: assert property (
    key_armed && wr_ctrl && !I_WDATA[`MESP_CTRL_EN]
    |=> !state_r.prot_en && !state_r.prot)
    else $error("keyed clear did not disable protection");

  // ------------------------------------------------------------
  // main scenarios
  // ------------------------------------------------------------
  // each cover marks a path the bench is expected to reach
  fall_c: cover property (flt_fall && state_r.prot_en ##1 state_r.prot);
  release_c: cover property (state_r.prot && release_ok ##1 !state_r.prot);
  disable_c: cover property (key_armed && wr_ctrl
    && !I_WDATA[`MESP_CTRL_EN] ##1 !state_r.prot_en);
  tool_c: cover property (!state_r.prot && tool_brk);
  lower_c: cover property (state_r.prot
    && state_r.mode == `MESP_MODE_LOWER_ON);
endmodule

/* File: sim/mesp_partner.sv */
// far-side model: emergency switch and the inverter gate drivers
// assumes i_trip comes from the bench, synchronous to i_clock
`timescale 1ns/100ps
module mesp_partner (
  input wire logic i_clock,
  input wire logic i_trip,
  input wire logic [5:0] i_phase,
  input wire logic [5:0] i_oe,
  output logic o_emg_n,
  output logic [5:0] o_gate
);
  logic [5:0] last = 6'h00;
  initial o_emg_n = 1'b1;
  // the switch line is pulled up, so it idles high between trips
  always @(posedge i_clock) begin
    o_emg_n <= ~i_trip;
    last <= o_gate;
  end
  // a floating gate input must not look like a held level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_gate[i] = i_oe[i] ? i_phase[i] : ~last[i];
    end
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the emergency-stop protection block
// assumes mesp_top, its package and the partner model compile first
`timescale 1ns/100ps
`include "mesp_defines.svh"
module testbench;
  import mesp_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, tool = 0, pmode = 0, trip = 0;
  logic irq, emg_n;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [11:0] cond = 12'h000;
  logic [5:0] pwm = 6'h00, pwm_d = 6'h00, ph, oe, gate;
  int failures = 0, total_checks = 0, seed = 88313;
  int m_en = 1, m_mode = 3, m_tool = 1, m_cnt = 0, m_prot = 0;
  int m_ist = 0, m_ien = 0, m_arm = 0;

  mesp_top dut (.I_CLOCK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_EMERGENCY_STOP_N(emg_n),
    .I_TOOL_STOP(tool), .I_TOOL_BREAK_PORT_MODE(pmode), .I_COND_BUF(cond),
    .I_PWM(pwm), .O_PHASE(ph), .O_PHASE_OE(oe), .O_EMERGENCY_INTERRUPT(irq));
  mesp_partner far (.i_clock(clk), .i_trip(trip), .i_phase(ph), .i_oe(oe),
    .o_emg_n(emg_n), .o_gate(gate));

  always #10 clk = ~clk;
  // pwm_d is the value the dut sampled at the last edge
  always @(posedge clk) begin
    pwm_d <= pwm;
    pwm <= 6'($random(seed));
  end

  // ----------------------------------------
  // tasks and model
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic report(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  function automatic logic [31:0] cv(input int c, t, m, r, e);
    return 32'(c * 256 + t * 32 + m * 8 + r * 2 + e);
  endfunction
  function automatic logic [31:0] mreg(input logic [7:0] a);
    case (a)
      `MESP_ADDR_CTRL: return cv(m_cnt, m_tool, m_mode, 0, m_en);
      `MESP_ADDR_STAT: return 32'(m_prot + (emg_n ? 2 : 0));
      `MESP_ADDR_ISTAT: return 32'(m_ist);
      `MESP_ADDR_IEN: return 32'(m_ien);
      default: return 32'h0;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask
  // one access; the model follows the key sequence and release checks
  task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int nxt;
    bit ok, key;
    bus(w, !w, a, d);
    ok = emg_n === 1'b1 && cond === 12'h000;
    key = w && a == `MESP_ADDR_KEY;
    nxt = 0;
    if (key && d[7:0] == `MESP_KEY_FIRST) nxt = 1;
    if (key && d[7:0] == `MESP_KEY_SECOND && m_arm == 1) nxt = 2;
    if (w && a == `MESP_ADDR_CTRL) begin
      if (d[0] || m_arm == 2) m_en = d[0];
      if (!d[0] && m_arm == 2) m_prot = 0;
      if (d[1] && ok) m_prot = 0;
      m_cnt = d[11:8];
      m_tool = d[5];
      m_mode = d[4:3];
    end
    if (w && a == `MESP_ADDR_ALTREL && d[0] && ok) m_prot = 0;
    if (w && a == `MESP_ADDR_ICLR) m_ist = m_ist & ~d[1:0];
    if (w && a == `MESP_ADDR_IEN) m_ien = d[1:0];
    m_arm = nxt;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  task automatic chk_rd(input logic [7:0] a);
    acc(1'b0, a, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    #1;
    report(mreg(a), rdata);
  endtask
  task automatic chk_pins();
    logic [5:0] e, p;
    #1;
    e = 6'h3F;
    p = pwm_d;
    if (m_prot != 0) e = m_mode == 1 ? 6'h07 : (m_mode == 2 ? 6'h38 : 6'h00);
    else if (m_tool != 0 && tool) begin
      e = pmode ? 6'h00 : 6'h3F;
      p = 6'h00;
    end
    report(32'({e, p & e, (m_ist & m_ien) != 0}), 32'({oe, gate & oe, irq}));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    tick(16);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4) chk_rd(8'(a));
    chk_pins();
    for (int md = 0; md < 4; md++) begin
      wr_reg(`MESP_ADDR_IEN, md == 3 ? 32'h0 : 32'h1);
      wr_reg(`MESP_ADDR_CTRL, cv(0, 1, md, 0, 1));
      trip <= 1'b1;
      tick(5);
      m_prot = 1;
      m_ist = m_ist | 1;
      chk_pins();
      wr_reg(`MESP_ADDR_CTRL, cv(0, 1, md, 1, 1));
      chk_rd(`MESP_ADDR_STAT);
      trip <= 1'b0;
      cond <= 12'($random(seed)) | 12'h001;
      tick(5);
      chk_rd(`MESP_ADDR_STAT);
      wr_reg(md[0] ? `MESP_ADDR_ALTREL : `MESP_ADDR_CTRL, cv(0, 1, md, 1, 1));
      chk_rd(`MESP_ADDR_STAT);
      cond <= 12'h000;
      wr_reg(md[0] ? `MESP_ADDR_ALTREL : `MESP_ADDR_CTRL, cv(0, 1, md, 1, 1));
      chk_rd(`MESP_ADDR_CTRL);
      chk_rd(`MESP_ADDR_STAT);
      chk_rd(`MESP_ADDR_ISTAT);
      wr_reg(`MESP_ADDR_ICLR, 32'h3);
      chk_pins();
    end
    // a read between the key bytes spoils the sequence
    acc(1'b1, `MESP_ADDR_KEY, `MESP_KEY_FIRST);
    acc(1'b0, `MESP_ADDR_STAT, 32'h0);
    acc(1'b1, `MESP_ADDR_KEY, `MESP_KEY_SECOND);
    wr_reg(`MESP_ADDR_CTRL, cv(0, 1, 3, 0, 0));
    chk_rd(`MESP_ADDR_CTRL);
    acc(1'b1, `MESP_ADDR_KEY, `MESP_KEY_FIRST);
    acc(1'b1, `MESP_ADDR_KEY, `MESP_KEY_SECOND);
    wr_reg(`MESP_ADDR_CTRL, cv(0, 1, 3, 0, 0));
    chk_rd(`MESP_ADDR_CTRL);
    trip <= 1'b1;
    tick(5);
    chk_pins();
    trip <= 1'b0;
    tick(5);
    wr_reg(`MESP_ADDR_CTRL, cv(0, 1, 3, 0, 1));
    wr_reg(`MESP_ADDR_CTRL, cv(0, 1, 3, 0, 0));
    chk_rd(`MESP_ADDR_CTRL);
    // filter of 2 x 16 clocks: quiet at 30, protected by 38
    wr_reg(`MESP_ADDR_CTRL, cv(2, 1, 3, 0, 1));
    // a one-cycle dip must not get through the filter
    trip <= 1'b1;
    tick(1);
    trip <= 1'b0;
    tick(4);
    chk_pins();
    trip <= 1'b1;
    tick(30);
    chk_pins();
    tick(8);
    m_prot = 1;
    m_ist = m_ist | 1;
    chk_pins();
    trip <= 1'b0;
    tick(40);
    wr_reg(`MESP_ADDR_CTRL, cv(0, 1, 3, 1, 1));
    chk_rd(`MESP_ADDR_STAT);
    wr_reg(`MESP_ADDR_IEN, 32'h2);
    for (int pm = 0; pm < 2; pm++) begin
      pmode <= pm[0];
      tool <= 1'b1;
      tick(3);
      m_ist = m_ist | 2;
      chk_pins();
      tool <= 1'b0;
      tick(3);
      chk_pins();
    end
    wr_reg(`MESP_ADDR_ICLR, 32'h3);
    wr_reg(`MESP_ADDR_CTRL, cv(0, 0, 3, 0, 1));
    tool <= 1'b1;
    tick(3);
    chk_pins();
    chk_rd(`MESP_ADDR_ISTAT);
    // reset with the switch open: protection comes up from startup
    tool <= 1'b0;
    trip <= 1'b1;
    tick(3);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    m_tool = 1;
    m_ien = 0;
    m_arm = 0;
    m_prot = 1;
    m_ist = 1;
    tick(4);
    chk_pins();
    chk_rd(`MESP_ADDR_CTRL);
    chk_rd(`MESP_ADDR_STAT);
    chk_rd(`MESP_ADDR_ISTAT);
    give_verdict();
  end
  // a hang counts as a failure
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule
